// *** wakeup_pkg.sv ***
package wakeup_pkg;

    // ==========================================================
    // register map (byte addresses, one word each)
    localparam int ADDR_W = 5;
    localparam logic [4:0] ADDR_FLAGS = 5'h00;
    localparam logic [4:0] ADDR_CONTROL = 5'h04;
    localparam logic [4:0] ADDR_CONFIG = 5'h08;
    localparam logic [4:0] ADDR_ALARM = 5'h0c;
    localparam logic [4:0] ADDR_STATUS = 5'h10;

    // ==========================================================
    // field positions
    localparam int FLG_RELEASE = 4;
    localparam int FLG_ALARM = 3;
    localparam int FLG_KICK = 2;
    localparam int FLG_WATCHDOG = 1;
    localparam int FLG_IRQ = 0;
    localparam int CTL_TRANSFER = 7;
    localparam int CTL_ALARM_PWR = 4;
    localparam int CTL_ALARM_IRQ = 3;
    localparam int CTL_KICK_IRQ = 2;
    localparam int CTL_WATCHDOG = 1;
    localparam int CFG_SQW_N = 0;
    localparam int CFG_BACKUP_SQW = 1;
    localparam int CFG_HOLD = 2;

    // ==========================================================
    // reset values
    localparam logic RELEASE_RESET = 1'b1;
    localparam logic SQW_N_RESET = 1'b1;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [31:0] ALARM_RESET = 32'h0000_0000;

    // ==========================================================
    // timing counts, in oscillator time-base ticks
    localparam int POWER_ON_TIMEOUT_TICKS = 1024;
    localparam int KICK_MIN_PULSE_TICKS = 4;

    // ==========================================================
    // types
    typedef struct packed {
        logic [7:0] day_date;
        logic [7:0] hours;
        logic [7:0] minutes;
        logic [7:0] seconds;
    } rtc_time_t;

    typedef struct packed {
        logic main_ok;
        logic above_pf;
        logic aux_present;
        logic osc_running;
    } supply_t;

    typedef enum logic [1:0] {PWR_OFF, PWR_WAIT, PWR_ON} power_state_t;

endpackage

// *** kick_detect.sv ***
`timescale 1ns/1ps
`default_nettype none

module kick_detect
    import wakeup_pkg::*;
#(
    parameter int MIN_TICKS = KICK_MIN_PULSE_TICKS
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic kick_input_n_i,
    input wire logic tick_i,
    output logic fall_o,
    output logic qualified_o
);

    localparam int CW = $clog2(MIN_TICKS + 1);

    logic prev;
    logic armed;
    logic [CW-1:0] count;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            prev <= 1'b1;
        end else begin
            prev <= kick_input_n_i;
        end
    end

    assign fall_o = prev & ~kick_input_n_i;

    // one qualified pulse per low period, once it has lasted the minimum width
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            count <= '0;
            armed <= 1'b1;
            qualified_o <= 1'b0;
        end else if (kick_input_n_i) begin
            count <= '0;
            armed <= 1'b1;
            qualified_o <= 1'b0;
        end else if (tick_i && armed) begin
            count <= count + CW'(1);
            qualified_o <= (count == CW'(MIN_TICKS - 1));
            armed <= (count != CW'(MIN_TICKS - 1));
        end else begin
            qualified_o <= 1'b0;
        end
    end

endmodule // kick_detect

`default_nettype wire

// *** wakeup_power_ctrl.sv ***
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RULE_01 - alarm wakeup only while power-enable is set
// RULE_02 - no wakeup unless transfers are enabled; the kick wakeup here does not check transfer enable
// RULE_03 - kick detection always on with aux battery
// RULE_04 - unpowered, compare time against alarm bytes
// RULE_05 - wakeup ignores alarm interrupt enable
// RULE_06 - alarm match drives request, sets alarm flag
// RULE_07 - qualified kick pulse drives request, sets flag
// RULE_08 - timeout without supply releases request
// RULE_09 - triggering flag kept after failed attempt
// RULE_10 - supply in time: keep request, irq, clear release
// RULE_11 - request held while release bit is zero
// RULE_12 - flags clear on read or zero write; here a write of one to the kick bit sets the kick flag
// RULE_13 - powered: match and kick edges set flags
// RULE_14 - enabled set flag drives interrupt low
// RULE_15 - powered events also drive the request
// RULE_16 - release write of one needs clear flags
// RULE_17 - interrupt floats below power-fail level
// RULE_18 - software clears flags before releasing power
// RULE_19 - powered down, hold-select decides request
// RULE_20 - square wave when enabled and oscillator runs
// RULE_21 - backup square wave needs enable and battery
// RULE_22 - detection needs oscillator and aux battery
// RULE_23 - release bit cleared by enabled alarm or kick
// RULE_24 - pending flag ORs the three enabled sources
// RULE_25 - timeout and pulse width are tick counts
module wakeup_power_ctrl
    import wakeup_pkg::*;
#(
    parameter int POWER_ON_TIMEOUT = POWER_ON_TIMEOUT_TICKS,
    parameter int KICK_MIN_PULSE = KICK_MIN_PULSE_TICKS
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire supply_t supply_i,
    input wire logic osc_tick_i,
    input wire logic second_tick_i,
    input wire rtc_time_t cur_time_i,
    input wire logic kick_input_n_i,
    input wire logic watchdog_timeout_i,
    input wire logic sqw_source_i,
    input wire logic power_request_n_i,
    output logic power_request_n_o,
    output logic power_request_oe_o,
    input wire logic irq_n_i,
    output logic irq_n_o,
    output logic irq_oe_o,
    output logic square_wave_out_o
);

    localparam int TW = $clog2(POWER_ON_TIMEOUT + 1);

    // ==========================================================
    // register bus
    logic ack;
    logic wr_done;
    logic rd_done;
    logic flags_wr;
    logic flags_rd;
    logic [31:0] read_mux;

    // one wait state: the data is muxed while waitrequest is high
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
    assign wr_done = avs_write_i & ack;
    assign rd_done = avs_read_i & ack;
    assign flags_wr = wr_done & (avs_address_i == ADDR_FLAGS) & avs_byteenable_i[0];
    assign flags_rd = rd_done & (avs_address_i == ADDR_FLAGS);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read_i | avs_write_i) & ~ack;
        end
    end

    // ==========================================================
    // software state
    logic release_bit;
    logic alarm_flag;
    logic kick_flag;
    logic watchdog_flag;
    logic transfer_enable;
    logic alarm_power_enable;
    logic alarm_irq_enable;
    logic kick_irq_enable;
    logic watchdog_enable;
    logic sqw_enable_n;
    logic backup_sqw_enable;
    logic power_hold_select;
    rtc_time_t alarm;
    power_state_t state;
    logic [TW-1:0] timeout_count;
    logic irq_pending_flag;
    logic sqw_active;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            transfer_enable <= CONTROL_RESET[CTL_TRANSFER];
            alarm_power_enable <= CONTROL_RESET[CTL_ALARM_PWR];
            alarm_irq_enable <= CONTROL_RESET[CTL_ALARM_IRQ];
            kick_irq_enable <= CONTROL_RESET[CTL_KICK_IRQ];
            watchdog_enable <= CONTROL_RESET[CTL_WATCHDOG];
        end else if (wr_done && avs_address_i == ADDR_CONTROL && avs_byteenable_i[0]) begin
            transfer_enable <= avs_writedata_i[CTL_TRANSFER];
            alarm_power_enable <= avs_writedata_i[CTL_ALARM_PWR];
            alarm_irq_enable <= avs_writedata_i[CTL_ALARM_IRQ];
            kick_irq_enable <= avs_writedata_i[CTL_KICK_IRQ];
            watchdog_enable <= avs_writedata_i[CTL_WATCHDOG];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sqw_enable_n <= SQW_N_RESET;
            backup_sqw_enable <= 1'b0;
            power_hold_select <= 1'b0;
        end else if (wr_done && avs_address_i == ADDR_CONFIG && avs_byteenable_i[0]) begin
            sqw_enable_n <= avs_writedata_i[CFG_SQW_N];
            backup_sqw_enable <= avs_writedata_i[CFG_BACKUP_SQW];
            power_hold_select <= avs_writedata_i[CFG_HOLD];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            alarm <= ALARM_RESET;
        end else if (wr_done && avs_address_i == ADDR_ALARM) begin
            for (int i = 0; i < 4; i++) begin
                if (avs_byteenable_i[i]) begin
                    alarm[i*8 +: 8] <= avs_writedata_i[i*8 +: 8];
                end
            end
        end
    end

    // ==========================================================
    // event detection
    logic monitor_ok;
    logic match_evt;
    logic alarm_set;
    logic alarm_wake;
    logic kick_fall;
    logic kick_qualified;
    logic kick_set;
    logic kick_wake;
    logic wake_start;

    // RULE_22 oscillator and battery gate
    assign monitor_ok = supply_i.osc_running & supply_i.aux_present;
    // RULE_02 transfer enable gates matching
    assign match_evt = second_tick_i & transfer_enable & monitor_ok & (cur_time_i == alarm);
    // RULE_01 RULE_04 power-enable gates unpowered compare
    assign alarm_wake = match_evt & alarm_power_enable & ~supply_i.main_ok;
    // RULE_13 powered alarm match
    assign alarm_set = match_evt & (supply_i.main_ok | alarm_power_enable);

    // RULE_25 pulse width in ticks
    kick_detect #(
        .MIN_TICKS(KICK_MIN_PULSE)
    ) u_kick (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .kick_input_n_i(kick_input_n_i),
        .tick_i(osc_tick_i),
        .fall_o(kick_fall),
        .qualified_o(kick_qualified)
    );

    // RULE_03 kick needs no enable bit
    assign kick_wake = monitor_ok & ~supply_i.main_ok & kick_qualified;
    // RULE_13 every powered falling edge counts while the oscillator runs and the aux battery is present
    assign kick_set = kick_wake | (monitor_ok & supply_i.main_ok & kick_fall);
    // RULE_05 alarm irq enable not consulted
    assign wake_start = (state == PWR_OFF) & (alarm_wake | kick_wake);

    // ==========================================================
    // flags: a set in the clearing cycle wins
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            alarm_flag <= 1'b0;
        end else begin
            // RULE_06 RULE_09 RULE_12 alarm flag, software clear only
            alarm_flag <= alarm_set
                | (alarm_flag & ~flags_rd & ~(flags_wr & ~avs_writedata_i[FLG_ALARM]));
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            kick_flag <= 1'b0;
        end else begin
            // RULE_07 RULE_12 kick flag set/clear
            kick_flag <= kick_set | (flags_wr & avs_writedata_i[FLG_KICK])
                | (kick_flag & ~flags_rd & ~flags_wr);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            watchdog_flag <= 1'b0;
        end else begin
            watchdog_flag <= watchdog_timeout_i
                | (watchdog_flag & ~flags_rd & ~(flags_wr & ~avs_writedata_i[FLG_WATCHDOG]));
        end
    end

    // ==========================================================
    // power sequencing
    logic timeout_hit;
    logic success;

    assign timeout_hit = timeout_count == TW'(POWER_ON_TIMEOUT);
    assign success = (state == PWR_WAIT) & supply_i.main_ok;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state <= PWR_OFF;
        end else begin
            unique case (state)
                PWR_OFF: begin
                    if (wake_start) begin
                        state <= PWR_WAIT;
                    end else if (supply_i.main_ok) begin
                        state <= PWR_ON;
                    end
                end
                PWR_WAIT: begin
                    // RULE_08 give up after timeout
                    if (supply_i.main_ok) begin
                        state <= PWR_ON;
                    end else if (timeout_hit) begin
                        state <= PWR_OFF;
                    end
                end
                PWR_ON: begin
                    if (!supply_i.main_ok) begin
                        state <= PWR_OFF;
                    end
                end
            endcase
        end
    end

    // RULE_25 timeout counted in ticks
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || state != PWR_WAIT) begin
            timeout_count <= '0;
        end else if (osc_tick_i && !timeout_hit) begin
            timeout_count <= timeout_count + TW'(1);
        end
    end

    // hardware clear beats a software write in the same cycle
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            release_bit <= RELEASE_RESET;
        // RULE_10 RULE_23 RULE_15 automatic clear
        end else if (success || (alarm_flag && alarm_power_enable) || kick_flag) begin
            release_bit <= 1'b0;
        // RULE_16 one only with flags clear
        end else if (flags_wr && (!avs_writedata_i[FLG_RELEASE] || (!alarm_flag && !kick_flag))) begin
            release_bit <= avs_writedata_i[FLG_RELEASE];
        end
    end

    // ==========================================================
    // pins
    // RULE_24 pending flag
    assign irq_pending_flag = (alarm_flag & alarm_irq_enable) | (kick_flag & kick_irq_enable)
        | (watchdog_flag & watchdog_enable);
    assign sqw_active = ~sqw_enable_n & supply_i.osc_running
        & (supply_i.main_ok | (backup_sqw_enable & supply_i.aux_present));

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            power_request_oe_o <= 1'b0;
            irq_oe_o <= 1'b0;
            square_wave_out_o <= 1'b0;
        end else begin
            // RULE_11 RULE_19 request drive
            power_request_oe_o <= (state == PWR_WAIT) | ((state == PWR_ON) & ~release_bit)
                | ((state == PWR_OFF) & power_hold_select);
            // RULE_14 RULE_17 interrupt drive
            irq_oe_o <= irq_pending_flag & supply_i.above_pf;
            // RULE_20 RULE_21 square wave gating
            square_wave_out_o <= sqw_active & sqw_source_i;
        end
    end

    // open-drain pins only ever pull low
    assign power_request_n_o = 1'b0;
    assign irq_n_o = 1'b0;

    // ==========================================================
    // read data
    always_comb begin
        read_mux = 32'h0000_0000;
        unique case (avs_address_i)
            ADDR_FLAGS: read_mux = {27'h0, release_bit, alarm_flag, kick_flag, watchdog_flag,
                irq_pending_flag};
            ADDR_CONTROL: read_mux = {24'h0, transfer_enable, 2'b00, alarm_power_enable,
                alarm_irq_enable, kick_irq_enable, watchdog_enable, 1'b0};
            ADDR_CONFIG: read_mux = {29'h0, power_hold_select, backup_sqw_enable, sqw_enable_n};
            ADDR_ALARM: read_mux = alarm;
            ADDR_STATUS: read_mux = {23'h0, sqw_active, irq_n_i, power_request_n_i, supply_i,
                state};
            default: read_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && !ack) begin
            avs_readdata_o <= read_mux;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_wait_fail;
        state == PWR_WAIT && timeout_hit && !supply_i.main_ok;
    endsequence

    sequence s_power_good;
        state == PWR_WAIT && supply_i.main_ok;
    endsequence

    property p_timeout_release;
        s_wait_fail |=> state == PWR_OFF ##1 power_request_oe_o == power_hold_select;
    endproperty
    a_timeout_release: assert property (p_timeout_release) else $error("request kept after timeout"); // RULE_08

    property p_success;
        s_power_good |=> state == PWR_ON && !release_bit ##1 power_request_oe_o;
    endproperty
    a_success: assert property (p_success) else $error("power-on not completed"); // RULE_10

    property p_hold_while_zero;
        state == PWR_ON && !release_bit |=> power_request_oe_o;
    endproperty
    a_hold_while_zero: assert property (p_hold_while_zero) else $error("request dropped"); // RULE_11

    property p_release_guard;
        flags_wr && avs_writedata_i[FLG_RELEASE] && (alarm_flag || kick_flag) && !release_bit
            |=> !release_bit;
    endproperty
    a_release_guard: assert property (p_release_guard) else $error("release accepted with flag"); // RULE_16

    property p_irq_drive;
        irq_pending_flag && supply_i.above_pf |=> irq_oe_o;
    endproperty
    a_irq_drive: assert property (p_irq_drive) else $error("interrupt not driven"); // RULE_14

    property p_irq_float;
        !supply_i.above_pf |=> !irq_oe_o;
    endproperty
    a_irq_float: assert property (p_irq_float) else $error("interrupt driven below fail level"); // RULE_17

    property p_no_transfer;
        !transfer_enable && !alarm_flag |=> !alarm_flag;
    endproperty
    a_no_transfer: assert property (p_no_transfer) else $error("alarm without transfers"); // RULE_02

    property p_wake;
        wake_start && alarm_wake |=> state == PWR_WAIT && alarm_flag ##1 power_request_oe_o;
    endproperty
    a_wake: assert property (p_wake) else $error("alarm wakeup missed"); // RULE_06

    property p_kick;
        kick_set |=> kick_flag;
    endproperty
    a_kick: assert property (p_kick) else $error("kick flag not set"); // RULE_07

    property p_read_clear;
        flags_rd && !alarm_set && !kick_set |=> !alarm_flag && !kick_flag;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("flags survive read"); // RULE_12

    property p_hold_select;
        state == PWR_OFF && $stable(state) && $stable(power_hold_select)
            |=> power_request_oe_o == $past(power_hold_select);
    endproperty
    a_hold_select: assert property (p_hold_select) else $error("hold select ignored"); // RULE_19

    property p_sqw_off;
        !sqw_active |=> !square_wave_out_o;
    endproperty
    a_sqw_off: assert property (p_sqw_off) else $error("square wave while disabled"); // RULE_21

endmodule // wakeup_power_ctrl

`default_nettype wire

// *** power_supply_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// main supply: turns on some cycles after the request pin goes low
module power_supply_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] delay_i,
    input wire logic req_n_i,
    input wire logic req_oe_i,
    input wire logic irq_n_i,
    input wire logic irq_oe_i,
    output logic req_pin_o,
    output logic irq_pin_o,
    output logic main_ok_o
);
    logic [3:0] cnt;

    // both pins are open drain with board pull-ups
    assign req_pin_o = req_oe_i ? req_n_i : 1'b1;
    assign irq_pin_o = irq_oe_i ? irq_n_i : 1'b1;

    // delay 0 is a supply that never comes up, so the timeout path is reachable
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || req_pin_o) begin
            cnt <= 4'h0;
            main_ok_o <= 1'b0;
        end else if (delay_i != 4'h0 && cnt == delay_i) begin
            main_ok_o <= 1'b1;
        end else if (delay_i != 4'h0) begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule // power_supply_model

`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import wakeup_pkg::*;
    localparam int TO = 4;
    localparam int KP = 2;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [4:0] avs_address_i = 5'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    supply_t supply_i;
    logic osc_tick_i = 1'b0;
    logic second_tick_i = 1'b0;
    rtc_time_t cur_time_i = 32'h0;
    logic kick_input_n_i = 1'b1;
    logic sqw_source_i = 1'b0;
    logic power_request_n_i, power_request_n_o, power_request_oe_o;
    logic irq_n_i, irq_n_o, irq_oe_o, square_wave_out_o;
    logic ext_on = 1'b0;
    logic aux = 1'b1;
    logic main_ok, src_prev;
    logic [3:0] delay = 4'h0;
    logic [1:0] tick_cnt = 2'h0;
    logic [31:0] seed = 32'h0000_17ec;
    int mismatches = 0;
    int cmp_count = 0;

    always #4 clk_i = ~clk_i;
    assign supply_i = {main_ok | ext_on, main_ok | ext_on, aux, 1'b1};

    // ==========================================================
    // time base: one osc tick every four clocks, square wave source
    always @(posedge clk_i) begin
        tick_cnt <= tick_cnt + 2'h1;
        osc_tick_i <= (tick_cnt == 2'h3);
        sqw_source_i <= tick_cnt[1];
        src_prev <= sqw_source_i;
    end

    wakeup_power_ctrl #(.POWER_ON_TIMEOUT(TO), .KICK_MIN_PULSE(KP)) u_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .supply_i(supply_i), .osc_tick_i(osc_tick_i),
        .second_tick_i(second_tick_i), .cur_time_i(cur_time_i), .kick_input_n_i(kick_input_n_i),
        .watchdog_timeout_i(1'b0), .sqw_source_i(sqw_source_i),
        .power_request_n_i(power_request_n_i), .power_request_n_o(power_request_n_o),
        .power_request_oe_o(power_request_oe_o), .irq_n_i(irq_n_i), .irq_n_o(irq_n_o),
        .irq_oe_o(irq_oe_o), .square_wave_out_o(square_wave_out_o));

    power_supply_model u_supply (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .delay_i(delay), .req_n_i(power_request_n_o),
        .req_oe_i(power_request_oe_o), .irq_n_i(irq_n_o), .irq_oe_i(irq_oe_o),
        .req_pin_o(power_request_n_i), .irq_pin_o(irq_n_i), .main_ok_o(main_ok));

    // ==========================================================
    // helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] flags(input logic rel, input logic al, input logic kk,
                                          input logic irq);
        return {27'h0, rel, al, kk, 1'b0, irq};
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic chkb(input string nm, input logic seen, input logic exp);
        chk(nm, {31'h0, seen}, {31'h0, exp});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // one bus access; waits for waitrequest low, then checks the wait took two cycles
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n = 0;
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        chk("bus wait", n, 32'd2);
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdc(input string nm, input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, q, exp);
    endtask

    task automatic wait_oe(input logic v, input int lim);
        int n = 0;
        while (power_request_oe_o !== v && n < lim) begin
            @(posedge clk_i);
            n++;
        end
    endtask

    task automatic kick(input int n);
        kick_input_n_i <= 1'b0;
        cyc(n);
        kick_input_n_i <= 1'b1;
        @(posedge clk_i);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        cyc(20000);
        mismatches++;
        $display("watchdog expired");
        finish_test();
    end

    // ==========================================================
    // main sequence
    initial begin
        logic [31:0] tm;
        logic [7:0] c;
        cyc(20);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        rdc("flags reset", ADDR_FLAGS, flags(1'b1, 1'b0, 1'b0, 1'b0));
        rdc("control reset", ADDR_CONTROL, 32'h0);
        rdc("config reset", ADDR_CONFIG, 32'h1);
        wr(5'h14, 32'hffff_ffff);
        rdc("unmapped", 5'h14, 32'h0);
        $display("test registers done");
        aux <= 1'b0;
        kick(16);
        chkb("kick no battery", power_request_oe_o, 1'b0);
        aux <= 1'b1;
        kick(4);
        cyc(4);
        chkb("short kick", power_request_oe_o, 1'b0);
        for (int k = 0; k < 3; k++) begin
            tm = rnd();
            wr(ADDR_ALARM, tm);
            cur_time_i <= (k == 2) ? tm ^ 32'h0000_0001 : tm;
            wr(ADDR_CONTROL, (k == 0) ? 32'h10 : (k == 1) ? 32'h80 : 32'h90);
            second_tick_i <= 1'b1;
            @(posedge clk_i);
            second_tick_i <= 1'b0;
            cyc(4);
            chkb("no wake", power_request_oe_o, 1'b0);
        end
        rdc("flags quiet", ADDR_FLAGS, flags(1'b1, 1'b0, 1'b0, 1'b0));
        $display("test disabled wake done");
        kick(12);
        wait_oe(1'b1, 10);
        chkb("kick wake", power_request_oe_o, 1'b1);
        wait_oe(1'b0, TO * 4 + 10);
        chkb("timeout release", power_request_oe_o, 1'b0);
        chkb("irq float", irq_oe_o, 1'b0);
        wr(ADDR_CONFIG, 32'h5);
        wait_oe(1'b1, 5);
        chkb("hold select", power_request_oe_o, 1'b1);
        wr(ADDR_CONFIG, 32'h1);
        rdc("kick kept", ADDR_FLAGS, flags(1'b0, 1'b0, 1'b1, 1'b0));
        wr(ADDR_FLAGS, 32'h10);
        $display("test failed attempt done");
        for (int k = 0; k < 2; k++) begin
            c = (k == 0) ? 8'h90 : 8'h98;
            delay <= 4'(rnd() % 8 + 1);
            tm = rnd();
            wr(ADDR_ALARM, tm);
            cur_time_i <= tm;
            wr(ADDR_CONTROL, {24'h0, c});
            second_tick_i <= 1'b1;
            @(posedge clk_i);
            second_tick_i <= 1'b0;
            wait_oe(1'b1, 10);
            chkb("alarm wake", power_request_oe_o, 1'b1);
            cyc(16);
            chkb("request kept", power_request_oe_o, 1'b1);
            chkb("irq on", irq_oe_o, c[3]);
            rdc("flags on", ADDR_FLAGS, flags(1'b0, 1'b1, 1'b0, c[3]));
            cyc(2);
            chkb("irq cleared", irq_oe_o, 1'b0);
            chkb("request held", power_request_oe_o, 1'b1);
            wr(ADDR_FLAGS, 32'h10);
            wait_oe(1'b0, 5);
            chkb("released", power_request_oe_o, 1'b0);
            cyc(4);
        end
        $display("test alarm wakeup done");
        delay <= 4'h0;
        ext_on <= 1'b1;
        wr(ADDR_CONTROL, 32'h04);
        kick(1);
        cyc(3);
        chkb("powered kick", power_request_oe_o, 1'b1);
        chkb("kick irq", irq_oe_o, 1'b1);
        ext_on <= 1'b0;
        cyc(3);
        chkb("irq below pf", irq_oe_o, 1'b0);
        ext_on <= 1'b1;
        cyc(3);
        wr(ADDR_FLAGS, 32'h14);
        rdc("release refused", ADDR_FLAGS, flags(1'b0, 1'b0, 1'b1, 1'b1));
        wr(ADDR_FLAGS, 32'h10);
        cyc(3);
        chkb("release taken", power_request_oe_o, 1'b0);
        chkb("irq idle", irq_oe_o, 1'b0);
        rdc("status", ADDR_STATUS, 32'h0000_00fe);
        $display("test powered events done");
        for (int k = 0; k < 3; k++) begin
            ext_on <= (k == 0);
            wr(ADDR_CONFIG, (k == 2) ? 32'h2 : 32'h0);
            cyc(3);
            repeat (8) begin
                @(posedge clk_i);
                chkb("square wave", square_wave_out_o, (k != 1) & src_prev);
            end
        end
        $display("test square wave done");
        finish_test();
    end
endmodule // tb_top

`default_nettype wire
